// file: logic/acp_command_port.sv
// module: serial command port front end with command word decode
`timescale 1ns/1ps
// Summary of operation
// - eight-bit command register, written by the host, never read back.
// - command word picks read or write and the target register.
// - after the selected transfer completes, port waits for a command again; while streaming it waits for ready low instead.
// - power-up and reset leave the port waiting for a command.
// - forty serial clocks with data-in high reset the whole port.
// - command word arrives most significant bit first.
// - fields gate, direction, select, stream bit, two zeros; all reset zero.
// - leading one holds the gate position; after a zero take seven bits.
// - direction zero writes the addressed register, one reads it.
// - select 000 is command or status, 8 bits; 001-011 are 24/32 bits.
// - 01011100 starts streaming reads; 01011000 with ready low stops them.
module acp_command_port (
  input  wire logic             MCLK,
  input  wire logic             NRST,
  input  wire logic             SCLK,
  input  wire logic             DIN,
  input  wire logic             CONV_READY_N,
  input  wire logic             DATA_APPEND,
  input  wire logic [31:0]      RD_DATA,
  output acp_pkg::acp_cmd_s     CMD_WORD,
  output logic                  DOUT,
  output logic                  XFER_BUSY,
  output logic                  STREAM_MODE,
  output logic                  WR_STROBE,
  output logic [31:0]           WR_DATA,
  output logic                  PART_RESET
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // length in serial clocks of the transfer a command selects
  function automatic logic [5:0] xfer_len(input acp_pkg::acp_cmd_s c, input logic app);
    logic [2:0] sel;
    sel = {c.register_select_msb, c.register_select_mid, c.register_select_lsb};
    if (sel == acp_pkg::SEL_MODE || sel == acp_pkg::SEL_CONFIG) begin
      xfer_len = acp_pkg::LEN_WIDE;
    end else if (sel == acp_pkg::SEL_DATA) begin
      xfer_len = app ? acp_pkg::LEN_DATA_S : acp_pkg::LEN_WIDE;
    end else begin
      xfer_len = acp_pkg::LEN_BYTE;
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  acp_pkg::acp_state_s st;
  acp_pkg::acp_state_s next_st;

  logic              rise;
  logic              fall;
  logic              bit_in;
  logic [7:0]        cmd_rx;
  acp_pkg::acp_cmd_s cmd_new;
  logic [2:0]        sel_new;
  logic [31:0]       rx_full;
  logic [31:0]       rd_aligned;

  // edges are found on the second sync stage, never the first
  assign rise       = st.sclk_s2 & ~st.sclk_d;
  assign fall       = ~st.sclk_s2 & st.sclk_d;
  assign bit_in     = st.din_s2;
  assign cmd_rx     = {1'b0, st.rx[5:0], bit_in};
  assign cmd_new    = acp_pkg::acp_cmd_s'(cmd_rx);
  assign sel_new    = cmd_rx[5:3];
  assign rx_full    = {st.rx[30:0], bit_in};
  // read data arrives right-aligned; shift it so its msb leaves first
  assign rd_aligned = RD_DATA << (acp_pkg::LEN_FULL - st.len);

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // one pass: synchronise pins, track the frame, decode, shift data
  always_comb begin
    next_st            = st;
    next_st.sclk_s1    = SCLK;
    next_st.sclk_s2    = st.sclk_s1;
    next_st.sclk_d     = st.sclk_s2;
    next_st.din_s1     = DIN;
    next_st.din_s2     = st.din_s1;
    next_st.wr_strobe  = 1'b0;
    next_st.part_reset = 1'b0;
    if (rise) begin
      next_st.ones = bit_in ? st.ones + 6'h01 : 6'h00;
      next_st.rx   = rx_full;
    end
    unique case (st.fsm)
      acp_pkg::ACP_IDLE: begin
        if (!st.stream) begin
          // a leading one is dropped; only a zero opens the word
          if (rise && !bit_in) begin
            next_st.fsm     = acp_pkg::ACP_CMD;
            next_st.bit_cnt = 6'h00;
          end
        end else if (fall && !CONV_READY_N) begin
          // streaming: data register goes out without a new command
          next_st.fsm     = acp_pkg::ACP_DATA;
          next_st.len     = xfer_len(st.cmd, DATA_APPEND);
          next_st.bit_cnt = 6'h00;
          next_st.first   = 1'b0;
          next_st.tx      = RD_DATA << (acp_pkg::LEN_FULL - xfer_len(st.cmd, DATA_APPEND));
          next_st.dout    = next_st.tx[31];
        end
      end
      acp_pkg::ACP_CMD: begin
        if (rise) begin
          next_st.bit_cnt = st.bit_cnt + 6'h01;
          if (st.bit_cnt == acp_pkg::CMD_TAIL) begin
            next_st.cmd     = cmd_new;
            next_st.bit_cnt = 6'h00;
            next_st.first   = 1'b1;
            next_st.len     = xfer_len(cmd_new, DATA_APPEND);
            if (cmd_rx == acp_pkg::STREAM_ON) begin
              next_st.stream = 1'b1;
              next_st.fsm    = acp_pkg::ACP_IDLE;
            end else if (!cmd_new.direction && sel_new == acp_pkg::SEL_COMMS) begin
              // a write to the command word is simply the next command
              next_st.fsm = acp_pkg::ACP_IDLE;
            end else begin
              next_st.fsm = acp_pkg::ACP_DATA;
            end
          end
        end
      end
      acp_pkg::ACP_DATA: begin
        // outgoing bits change on falling edges, host samples late in the high phase
        if (fall) begin
          if (st.first) begin
            next_st.tx    = rd_aligned;
            next_st.dout  = rd_aligned[31];
            next_st.first = 1'b0;
          end else begin
            next_st.tx   = st.tx << 1;
            next_st.dout = st.tx[30];
          end
        end
        if (rise) begin
          next_st.bit_cnt = st.bit_cnt + 6'h01;
          // ready was low when the stream frame began, so stop is legal
          if (st.stream && st.bit_cnt == acp_pkg::OFF_SPAN
              && rx_full[7:0] == acp_pkg::STREAM_OFF) begin
            next_st.stream = 1'b0;
          end
          if (st.bit_cnt == st.len - 6'h01) begin
            next_st.fsm = acp_pkg::ACP_IDLE;
            if (!st.cmd.direction) begin
              next_st.wr_strobe = 1'b1;
              next_st.wr_data   = rx_full & (32'hFFFF_FFFF >> (acp_pkg::LEN_FULL - st.len));
            end
          end
        end
      end
      default: begin
        next_st.fsm = acp_pkg::ACP_IDLE;
      end
    endcase
    // framing recovery outranks everything else in the cycle
    if (rise && bit_in && st.ones == acp_pkg::ONES_RESET - 6'h01) begin
      next_st            = acp_pkg::ST_RESET;
      next_st.sclk_s1    = SCLK;
      next_st.sclk_s2    = st.sclk_s1;
      next_st.sclk_d     = st.sclk_s2;
      next_st.din_s1     = DIN;
      next_st.din_s2     = st.din_s1;
      next_st.part_reset = 1'b1;
    end
    next_st.busy = (next_st.fsm == acp_pkg::ACP_DATA);
  end

  // state register; reset leaves the port awaiting a command
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st <= acp_pkg::ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state register
  // ****************************************************************
  assign CMD_WORD    = st.cmd;
  assign DOUT        = st.dout;
  assign XFER_BUSY   = st.busy;
  assign STREAM_MODE = st.stream;
  assign WR_STROBE   = st.wr_strobe;
  assign WR_DATA     = st.wr_data;
  assign PART_RESET  = st.part_reset;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  a_part_reset_idle: assert property (PART_RESET |-> st.fsm == acp_pkg::ACP_IDLE
    && st.cmd == acp_pkg::CMD_RESET && !st.stream) else $error("port not idle after run reset");
  a_ones_run_resets: assert property (rise && bit_in && st.ones == 6'h27 |=> PART_RESET)
    else $error("forty ones did not reset the port");
  a_gate_one_holds: assert property (st.fsm == acp_pkg::ACP_IDLE && !st.stream && rise
    && bit_in && st.ones != 6'h27 |=> st.fsm == acp_pkg::ACP_IDLE) else $error("one left gate");
  a_cmd_msb_first: assert property (st.fsm == acp_pkg::ACP_CMD && rise && st.bit_cnt == 6'h06
    && !(bit_in && st.ones == 6'h27) |=> st.cmd.fixed_zero[0] == $past(bit_in)
    && st.cmd.stream_read_bit == $past(st.rx[1]) && !st.cmd.write_gate)
    else $error("command bits misordered");
  a_write_dir_zero: assert property (WR_STROBE |-> !st.cmd.direction
    && st.fsm == acp_pkg::ACP_IDLE) else $error("write strobe without write command");
  a_wide_len: assert property (st.busy && (st.cmd[5:3] == acp_pkg::SEL_MODE
    || st.cmd[5:3] == acp_pkg::SEL_CONFIG) |-> st.len == 6'h18) else $error("bad wide length");
  a_status_byte: assert property (st.busy && st.cmd.direction
    && st.cmd[5:3] == acp_pkg::SEL_COMMS |-> st.len == 6'h08) else $error("bad status length");
  a_stream_cause: assert property ($rose(STREAM_MODE) |-> st.cmd == acp_pkg::STREAM_ON
    && st.fsm == acp_pkg::ACP_IDLE) else $error("stream set without its command");
  a_xfer_ends_idle: assert property (st.busy && rise && st.bit_cnt == st.len - 6'h01
    |=> !XFER_BUSY) else $error("transfer did not end");
  a_dout_on_fall: assert property (!$stable(DOUT) |-> $past(fall) || PART_RESET)
    else $error("data out moved off a falling edge");

  c_read_done:  cover property (st.busy && st.cmd.direction ##1 !st.busy);
  c_write_done: cover property (WR_STROBE);
  c_stream_on:  cover property ($rose(STREAM_MODE));
  c_run_reset:  cover property (PART_RESET);

endmodule

// file: logic/acp_pkg.sv
// package: constants and types of the serial command port
package acp_pkg;

  // ****************************************************************
  // command word layout and fixed command values
  // ****************************************************************
  typedef struct packed {
    logic       write_gate;          // bit 7, first bit on the wire
    logic       direction;           // bit 6, one means read
    logic       register_select_msb; // bit 5
    logic       register_select_mid; // bit 4
    logic       register_select_lsb; // bit 3
    logic       stream_read_bit;     // bit 2
    logic [1:0] fixed_zero;          // bits 1..0
  } acp_cmd_s;

  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] STREAM_ON  = 8'h5C;
  localparam logic [7:0] STREAM_OFF = 8'h58;

  // ****************************************************************
  // register selects and transfer lengths in serial clocks
  // ****************************************************************
  localparam logic [2:0] SEL_COMMS  = 3'h0;
  localparam logic [2:0] SEL_MODE   = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h2;
  localparam logic [2:0] SEL_DATA   = 3'h3;
  localparam logic [5:0] LEN_BYTE   = 6'h08;
  localparam logic [5:0] LEN_WIDE   = 6'h18;
  localparam logic [5:0] LEN_DATA_S = 6'h20;
  localparam logic [5:0] LEN_FULL   = 6'h20;
  localparam logic [5:0] CMD_TAIL   = 6'h06;
  localparam logic [5:0] OFF_SPAN   = 6'h07;

  // run of ones on the data input that resets the whole port
  localparam logic [5:0] ONES_RESET = 6'h28;

  // ****************************************************************
  // port state
  // ****************************************************************
  typedef enum logic [1:0] {
    ACP_IDLE = 2'b00,
    ACP_CMD  = 2'b01,
    ACP_DATA = 2'b11
  } acp_fsm_e;

  typedef struct packed {
    acp_fsm_e    fsm;
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_d;
    logic        din_s1;
    logic        din_s2;
    logic [5:0]  bit_cnt;
    logic [5:0]  len;
    logic [5:0]  ones;
    logic [31:0] rx;
    logic [31:0] tx;
    logic        first;
    acp_cmd_s    cmd;
    logic        stream;
    logic        dout;
    logic        busy;
    logic        wr_strobe;
    logic [31:0] wr_data;
    logic        part_reset;
  } acp_state_s;

  // serial clock sync stages start at the pin's idle high level, so that
  // releasing reset does not show a false rising edge
  localparam acp_state_s ST_RESET = '{fsm: ACP_IDLE, dout: 1'b1, sclk_s1: 1'b1,
                                      sclk_s2: 1'b1, sclk_d: 1'b1, default: '0};

endpackage

// file: tb/acp_host.sv
// host side model: serial master that frames command and data words
`timescale 1ns/1ps
module acp_host (
  output logic      SCLK,
  output logic      DIN,
  input  wire logic DOUT
);
  // half period in ns, giving a 200 ns serial clock
  int half = 100;

  // clock idles high between frames, data held low so no ones pile up
  initial begin
    SCLK = 1'b1;
    DIN  = 1'b0;
  end

  // ****************************************************************
  // frame tasks
  // ****************************************************************
  // shift n bits msb first; reply taken late in the high phase, where it is settled
  task automatic shift(input int n, input logic [39:0] tx, output logic [39:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      SCLK = 1'b0;
      DIN  = tx[i];
      #(half);
      SCLK = 1'b1;
      #(half - 5);
      rx = {rx[38:0], DOUT};
      // drop data late in the last high phase so a following call never
      // drives the data line twice in one time step
      if (i == 0) DIN = 1'b0;
      #5;
    end
  endtask

  // every non-streaming transaction opens with a command word, gate bit zero first
  task automatic command(input logic [7:0] c);
    logic [39:0] rx;
    shift(8, {32'h0, c}, rx);
  endtask
endmodule

// file: tb/adc_serial_command_port_tb.sv
// testbench: command port driven through the host serial model
`timescale 1ns/1ps
module adc_serial_command_port_tb;
  logic               mclk = 1'b0;
  logic               nrst = 1'b0;
  logic               conv_ready_n = 1'b1;
  logic               data_append = 1'b0;
  logic [31:0]        rd_data = '0;
  wire logic          sclk;
  wire logic          din;
  acp_pkg::acp_cmd_s  cmd_word;
  logic               dout, xfer_busy, stream_mode, wr_strobe, part_reset;
  logic [31:0]        wr_data, mask, base;
  logic [39:0]        rx;
  int                 mismatches = 0, n_checks = 0, cycles = 0, n_strobe = 0, n_reset = 0;

  // transfer table: writes of every length, then reads incl. status
  localparam logic [7:0]  T_CMD [8] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h40, 8'h48, 8'h58, 8'h58};
  localparam int          T_LEN [8] = '{24, 24, 32, 8, 8, 24, 24, 32};
  localparam logic [31:0] T_VAL [8] = '{32'h00A5_C396, 32'h003C_0FF0, 32'h8421_7BDE,
                                        32'h0000_0081, 32'h0000_00A6, 32'h005A_C33C,
                                        32'h1234_5678, 32'h1234_5678};

  always #12.5 mclk = ~mclk;

  acp_host acp_host_inst (.SCLK(sclk), .DIN(din), .DOUT(dout));

  acp_command_port acp_command_port_inst (
    .MCLK(mclk), .NRST(nrst), .SCLK(sclk), .DIN(din), .CONV_READY_N(conv_ready_n),
    .DATA_APPEND(data_append), .RD_DATA(rd_data), .CMD_WORD(cmd_word), .DOUT(dout),
    .XFER_BUSY(xfer_busy), .STREAM_MODE(stream_mode), .WR_STROBE(wr_strobe),
    .WR_DATA(wr_data), .PART_RESET(part_reset));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // pulse counters and the hang guard; a frame run needs well under 10k cycles
  always @(posedge mclk) begin
    cycles++;
    if (wr_strobe === 1'b1) n_strobe++;
    if (part_reset === 1'b1) n_reset++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    tick(20);
    nrst = 1'b1;
    tick(3);
    chk("reset cmd_word", 32'h0, {24'h0, cmd_word});
    chk("reset dout", 32'h1, {31'h0, dout});
    // every transfer kind; entry 4 leads with ones
    for (int k = 0; k < 8; k++) begin
      mask = (T_LEN[k] == 32) ? 32'hFFFF_FFFF : (32'h1 << T_LEN[k]) - 32'h1;
      data_append = (T_LEN[k] == 32);
      rd_data = T_VAL[k];
      base = n_strobe;
      if (k == 4) acp_host_inst.shift(3, '1, rx);
      acp_host_inst.command(T_CMD[k]);
      chk("busy in frame", 32'h1, {31'h0, xfer_busy});
      acp_host_inst.shift(T_LEN[k], T_CMD[k][6] ? 40'h0 : {8'h0, T_VAL[k]}, rx);
      tick(4);
      chk("cmd_word", {24'h0, T_CMD[k]}, {24'h0, cmd_word});
      chk("busy", 32'h0, {31'h0, xfer_busy});
      if (T_CMD[k][6]) chk("read data", T_VAL[k] & mask, rx[31:0] & mask);
      else chk("write data", T_VAL[k] & mask, wr_data);
      if (!T_CMD[k][6]) chk("strobes", base + 1, n_strobe);
    end
    // 39 ones leave the port alone, the 40th resets it
    base = n_reset;
    acp_host_inst.shift(39, '1, rx);
    tick(4);
    chk("no run reset", base, n_reset);
    acp_host_inst.shift(1, '1, rx);
    tick(4);
    chk("run reset", base + 1, n_reset);
    chk("cmd_word cleared", 32'h0, {24'h0, cmd_word});
    // streaming: enable, one frame on ready low, then stop inside a frame
    acp_host_inst.command(acp_pkg::STREAM_ON);
    tick(4);
    chk("stream on", 32'h1, {31'h0, stream_mode});
    data_append = 1'b0;
    rd_data = 32'h00C0_FFEE;
    conv_ready_n = 1'b0;
    acp_host_inst.shift(24, 40'h0, rx);
    tick(4);
    conv_ready_n = 1'b1;
    chk("stream read", 32'h00C0_FFEE, rx[31:0]);
    chk("stream kept", 32'h1, {31'h0, stream_mode});
    rd_data = 32'h0012_3456;
    conv_ready_n = 1'b0;
    acp_host_inst.shift(24, {16'h0, acp_pkg::STREAM_OFF, 16'h0}, rx);
    tick(4);
    conv_ready_n = 1'b1;
    chk("stop frame", 32'h0012_3456, rx[31:0]);
    chk("stream off", 32'h0, {31'h0, stream_mode});
    test_done();
  end
endmodule
